// >>> design/mami_pkg.sv
// Shared constants and carrier types of the multi-axis motion pin logic
package mami_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NAXES = 8;
  localparam int NIN   = 16;
  localparam int NOUT  = 8;
  localparam int CMD_W = 16;
  localparam int POS_W = 32;
  localparam int PWM_W = 11;
  localparam int SEL_W = 3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ      = 20_000_000;
  localparam int PWM_FREQ_HZ = 16_700;
  localparam int PWM_PERIOD  = CLK_HZ / PWM_FREQ_HZ;
  localparam logic [PWM_W-1:0] PWM_LAST = PWM_W'(PWM_PERIOD - 1);

  // ----------------------------------------
  // Duty figures, in tenths of a percent
  // ----------------------------------------
  localparam int PML_FULL    = 1000;
  localparam int INV_MIN_PML = 2;
  localparam int INV_MAX_PML = 998;
  localparam int SM_MAX_PML  = 996;
  localparam logic [PWM_W-1:0] INV_MIN_CYC  = PWM_W'(PWM_PERIOD * INV_MIN_PML / PML_FULL);
  localparam logic [PWM_W-1:0] INV_SPAN_CYC =
    PWM_W'(PWM_PERIOD * (INV_MAX_PML - INV_MIN_PML) / PML_FULL);
  localparam logic [PWM_W-1:0] SM_SPAN_CYC  = PWM_W'(PWM_PERIOD * SM_MAX_PML / PML_FULL);
  localparam int INV_SHIFT = 16;
  localparam int SM_SHIFT  = 15;
  localparam logic [CMD_W-1:0] CMD_MID = 16'h8000;

  // ----------------------------------------
  // Latch trigger mapping (input index of axis 0 and axis 4)
  // ----------------------------------------
  localparam int LATCH_LO_BASE = 0;
  localparam int LATCH_HI_BASE = 8;
  localparam int LATCH_HI_AXIS = 4;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    HS_IDLE  = 4'b0001,
    HS_ARMED = 4'b0010,
    HS_SLEW  = 4'b0100,
    HS_INDEX = 4'b1000
  } mami_home_e;

  typedef struct packed {
    logic encoder_channel_one;
    logic encoder_channel_two;
    logic idx;
    logic aux_a;
    logic aux_b;
  } mami_enc_s;

  typedef struct packed {
    logic signed [CMD_W-1:0] motor_cmd;
    logic [CMD_W-1:0]        motor_off_level_cmd;
    logic [CMD_W-1:0]        error_limit_cmd;
    logic signed [POS_W-1:0] pos_err;
    logic                    motor_on;
    logic                    stepper;
    logic                    pulse_dir_fb;
    logic                    off_on_error_setting;
    logic                    step_run;
    logic                    step_fwd;
    logic [CMD_W-1:0]        step_half;
    logic                    homing_cmd;
    logic                    find_edge_cmd;
    logic                    find_index_cmd;
    logic                    begin_motion_cmd;
    logic                    latch_arm_cmd;
  } mami_axis_cmd_s;

  typedef struct packed {
    logic limit_active_high;
    logic step_active_low;
  } mami_pol_s;

  typedef struct packed {
    logic             set_output_bit_cmd;
    logic             clear_output_bit_cmd;
    logic             output_port_write_cmd;
    logic [SEL_W-1:0] bit_sel;
    logic [NOUT-1:0]  port_val;
  } mami_out_cmd_s;

  typedef struct packed {
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] aux_pos;
    logic [POS_W-1:0] latch_pos;
    logic             latch_valid;
    logic             latch_armed;
    logic             slewing;
    logic             home_stop;
    logic             index_found;
  } mami_axis_sts_s;

endpackage

// >>> design/mami_top.sv
// Multi-axis motion pin logic: drive outputs, encoder decode, switches and latches
//
// Contract
// - Motor command refreshed each sample tick; held at motor-off level when off.
// - Amplifier enable goes low on abort or on motor-off-on-error.
// - Servo PWM runs at a fixed 16.7 kHz.
// - Inverter PWM maps command linearly: .2% to 50% to 99.8% duty.
// - Sign-magnitude PWM (jumper): 0% to 99.6% duty, polarity on sign output.
// - Stepper axes emit 50% duty step pulses with selectable polarity.
// - After reset step output is low with jumper, else high impedance.
// - Sign/direction shows command polarity (servo) or motion direction (stepper).
// - Error output low while any axis position error exceeds its limit.
// - Eight outputs set or cleared per bit, or written all at once.
// - Quadrature decoded at four counts per encoder cycle.
// - Pulse-and-direction mode counts channel one pulses, direction from channel two.
// - Index pulse defines home during homing and find-index.
// - Auxiliary encoder only counts on axes not configured as stepper.
// - Low abort stops motion at once and halts the motion program.
// - Low reset input returns to power-on state and requests a restore; here it clears positions, latch flags, homing, outputs and drive enable only.
// - Active limit inhibits motion that way and fires the limit handler.
// - Begin after homing or find-edge slews; home transition pulses the home_stop status.
// - Uncommitted inputs are offered as levels and change events.
// - Armed latch captures axis position on the latch signal.
// - Inputs 1-4 latch axes 1-4, inputs 9-12 latch axes 5-8.
module mami_top (
  // Clock and reset
  input  wire logic                                         sys_clk,
  input  wire logic                                         rst_n,
  // System pins
  input  wire logic                                         sign_magnitude_jumper,
  input  wire logic                                         abort_n,
  input  wire logic                                         reset_in_n,
  // Axis pins
  input  wire mami_pkg::mami_enc_s  [mami_pkg::NAXES-1:0]   enc_pins,
  input  wire logic                 [mami_pkg::NAXES-1:0]   lim_fwd,
  input  wire logic                 [mami_pkg::NAXES-1:0]   lim_rev,
  input  wire logic                 [mami_pkg::NAXES-1:0]   home_sw,
  input  wire logic                 [mami_pkg::NIN-1:0]     gen_in,
  // Controller side
  input  wire logic                                         sample_tick,
  input  wire logic                                         latch_enable,
  input  wire mami_pkg::mami_axis_cmd_s [mami_pkg::NAXES-1:0] axis_cmd,
  input  wire mami_pkg::mami_pol_s                          switch_polarity_cfg,
  input  wire mami_pkg::mami_out_cmd_s                      out_cmd,
  // Motor pins
  output logic [mami_pkg::NAXES-1:0][mami_pkg::CMD_W-1:0]   motor_cmd_out,
  output logic [mami_pkg::NAXES-1:0]                        pwm_step_o,
  output logic [mami_pkg::NAXES-1:0]                        pwm_step_oe,
  output logic [mami_pkg::NAXES-1:0]                        sign_dir_o,
  output logic [mami_pkg::NAXES-1:0]                        amp_en_o,
  output logic                                              err_out_n,
  output logic [mami_pkg::NOUT-1:0]                         uout,
  // Status
  output mami_pkg::mami_axis_sts_s [mami_pkg::NAXES-1:0]    axis_sts,
  output logic [mami_pkg::NIN-1:0]                          input_state,
  output logic [mami_pkg::NIN-1:0]                          input_change,
  output logic [mami_pkg::NAXES-1:0]                        limit_handler_routine,
  output logic                                              motion_halt,
  output logic                                              restore_req
);

  localparam int NA  = mami_pkg::NAXES;
  localparam int EW  = $bits(mami_pkg::mami_enc_s);
  localparam int SYW = NA * EW + 3 * NA + mami_pkg::NIN + 1;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic signed [1:0] quad_step(input logic [1:0] p, input logic [1:0] c);
    case ({p, c})
      4'h1, 4'h7, 4'he, 4'h8: quad_step = 2'sb01;
      4'h2, 4'hb, 4'hd, 4'h4: quad_step = 2'sb11;
      default:                quad_step = 2'sb00;
    endcase
  endfunction

  function automatic logic [mami_pkg::POS_W-1:0] sx2(input logic [1:0] d);
    sx2 = {{(mami_pkg::POS_W-2){d[1]}}, d};
  endfunction

  function automatic logic [mami_pkg::PWM_W-1:0] duty_scale(
    input logic [mami_pkg::CMD_W:0]   v,
    input logic [mami_pkg::PWM_W-1:0] span,
    input int unsigned                sh
  );
    logic [mami_pkg::CMD_W+mami_pkg::PWM_W:0] p;
    p = {{mami_pkg::PWM_W{1'b0}}, v} * {{(mami_pkg::CMD_W+1){1'b0}}, span};
    duty_scale = mami_pkg::PWM_W'(p >> sh);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Control pins reset to their idle high level so release does not look like an abort
  logic [SYW-1:0] sy1_r;
  logic [SYW-1:0] sy2_r;
  logic [1:0]     cs1_r;
  logic [1:0]     cs2_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_r <= '0;
      sy2_r <= '0;
      cs1_r <= '1;
      cs2_r <= '1;
    end else begin
      sy1_r <= {sign_magnitude_jumper, gen_in, home_sw, lim_rev, lim_fwd, enc_pins};
      sy2_r <= sy1_r;
      cs1_r <= {abort_n, reset_in_n};
      cs2_r <= cs1_r;
    end
  end

  mami_pkg::mami_enc_s [NA-1:0]    enc_s;
  logic [NA-1:0]                   fwd_s;
  logic [NA-1:0]                   rev_s;
  logic [NA-1:0]                   home_s;
  logic [mami_pkg::NIN-1:0]        gin_s;
  logic                            jmp_s;
  wire                             abort_act = ~cs2_r[1];
  wire                             soft_clr  = ~cs2_r[0];

  assign {jmp_s, gin_s, home_s, rev_s, fwd_s, enc_s} = sy2_r;

  // ----------------------------------------
  // Global registers
  // ----------------------------------------
  logic [mami_pkg::PWM_W-1:0] pwm_cnt_r;
  logic [NA-1:0]              err_over;
  logic                       err_out_n_r;
  logic [mami_pkg::NOUT-1:0]  uout_r;
  logic [mami_pkg::NIN-1:0]   in_state_r;
  logic [mami_pkg::NIN-1:0]   in_change_r;
  logic                       halt_r;
  logic                       soft_q_r;
  logic                       restore_r;

  wire [mami_pkg::NOUT-1:0] bit_mask = mami_pkg::NOUT'(1) << out_cmd.bit_sel;
  wire [mami_pkg::NOUT-1:0] set_mask = out_cmd.set_output_bit_cmd   ? bit_mask : '0;
  wire [mami_pkg::NOUT-1:0] clr_mask = out_cmd.clear_output_bit_cmd ? bit_mask : '0;
  wire [mami_pkg::NOUT-1:0] uout_nxt = out_cmd.output_port_write_cmd ? out_cmd.port_val
                                       : (uout_r | set_mask) & ~clr_mask;
  wire pwm_wrap = (pwm_cnt_r == mami_pkg::PWM_LAST);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt_r   <= '0;
      err_out_n_r <= 1'b1;
      uout_r      <= '0;
      in_state_r  <= '0;
      in_change_r <= '0;
      halt_r      <= 1'b0;
      soft_q_r    <= 1'b0;
      restore_r   <= 1'b0;
    end else begin
      pwm_cnt_r   <= pwm_wrap ? '0 : pwm_cnt_r + 1'b1;
      err_out_n_r <= ~|err_over;
      uout_r      <= soft_clr ? '0 : uout_nxt;
      in_state_r  <= gin_s;
      in_change_r <= gin_s ^ in_state_r;
      halt_r      <= abort_act;
      soft_q_r    <= soft_clr;
      restore_r   <= soft_q_r & ~soft_clr;
    end
  end

  assign err_out_n    = err_out_n_r;
  assign uout         = uout_r;
  assign input_state  = in_state_r;
  assign input_change = in_change_r;
  assign motion_halt  = halt_r;
  assign restore_req  = restore_r;

  // ----------------------------------------
  // Per-axis logic
  // ----------------------------------------
  for (genvar a = 0; a < NA; a++) begin : g_ax
    mami_pkg::mami_axis_cmd_s c;
    mami_pkg::mami_enc_s      e;
    mami_pkg::mami_enc_s      eq_r;
    mami_pkg::mami_home_e     hs_r;
    logic [mami_pkg::POS_W-1:0] pos_r;
    logic [mami_pkg::POS_W-1:0] aux_r;
    logic [mami_pkg::POS_W-1:0] lpos_r;
    logic                       lval_r;
    logic                       larm_r;
    logic                       hm_mode_r;
    logic                       fi_mode_r;
    logic                       stop_r;
    logic                       idxf_r;
    logic                       home_q_r;
    logic                       lim_q_r;
    logic                       lim_ev_r;
    logic [mami_pkg::CMD_W-1:0] mcmd_r;
    logic [mami_pkg::CMD_W-1:0] scnt_r;
    logic                       sph_r;
    logic                       drv_r;
    logic                       pwm_r;
    logic                       oe_r;
    logic                       sgn_r;
    logic                       amp_r;

    assign c = axis_cmd[a];
    assign e = enc_s[a];

    // Encoder decode
    wire signed [1:0] q_main = quad_step({eq_r.encoder_channel_one, eq_r.encoder_channel_two}, {e.encoder_channel_one, e.encoder_channel_two});
    wire signed [1:0] q_pd   = (e.encoder_channel_one & ~eq_r.encoder_channel_one) ? (e.encoder_channel_two ? 2'sb11 : 2'sb01)
                               : 2'sb00;
    wire signed [1:0] q_use  = c.pulse_dir_fb ? q_pd : q_main;
    wire signed [1:0] q_aux  = quad_step({eq_r.aux_a, eq_r.aux_b}, {e.aux_a, e.aux_b});
    wire              idx_rise = e.idx & ~eq_r.idx;
    wire              home_tr  = home_s[a] ^ home_q_r;

    // Limits and error
    wire fwd_act = ~(fwd_s[a] ^ switch_polarity_cfg.limit_active_high);
    wire rev_act = ~(rev_s[a] ^ switch_polarity_cfg.limit_active_high);
    wire signed [mami_pkg::POS_W:0] err_x = {c.pos_err[mami_pkg::POS_W-1], c.pos_err};
    wire [mami_pkg::POS_W:0] err_abs = err_x[mami_pkg::POS_W] ? -err_x : err_x;
    assign err_over[a] = err_abs > {{(mami_pkg::POS_W-mami_pkg::CMD_W+1){1'b0}},
                                    c.error_limit_cmd};
    wire off_err   = c.off_on_error_setting & err_over[a];
    wire motor_off = ~c.motor_on | abort_act | off_err;
    wire cmd_neg   = c.motor_cmd[mami_pkg::CMD_W-1];
    wire cmd_blk   = (~cmd_neg & |c.motor_cmd & fwd_act) | (cmd_neg & rev_act);
    wire [mami_pkg::CMD_W-1:0] cmd_nxt = motor_off ? c.motor_off_level_cmd
                                        : cmd_blk ? '0 : c.motor_cmd;

    // PWM duty thresholds
    wire [mami_pkg::CMD_W:0] inv_v = {1'b0, mcmd_r ^ mami_pkg::CMD_MID};
    wire signed [mami_pkg::CMD_W:0] mx = {mcmd_r[mami_pkg::CMD_W-1], mcmd_r};
    wire [mami_pkg::CMD_W:0] mag_v = mx[mami_pkg::CMD_W] ? -mx : mx;
    wire [mami_pkg::PWM_W-1:0] th_inv = mami_pkg::INV_MIN_CYC
      + duty_scale(inv_v, mami_pkg::INV_SPAN_CYC, mami_pkg::INV_SHIFT);
    wire [mami_pkg::PWM_W-1:0] th_sm =
      duty_scale(mag_v, mami_pkg::SM_SPAN_CYC, mami_pkg::SM_SHIFT);
    wire [mami_pkg::PWM_W-1:0] th = jmp_s ? th_sm : th_inv;

    // Step generator
    wire step_go = c.stepper & c.step_run & ~motor_off
                   & ~(c.step_fwd ? fwd_act : rev_act);
    wire step_lvl = sph_r ^ switch_polarity_cfg.step_active_low;

    // Latch trigger select
    localparam int LIN = (a < mami_pkg::LATCH_HI_AXIS) ? mami_pkg::LATCH_LO_BASE + a
                         : mami_pkg::LATCH_HI_BASE + a - mami_pkg::LATCH_HI_AXIS;
    wire latch_hit = latch_enable & larm_r & gin_s[LIN];

    // Position, aux and latch
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        eq_r   <= '0;
        pos_r  <= '0;
        aux_r  <= '0;
        lpos_r <= '0;
        lval_r <= 1'b0;
        larm_r <= 1'b0;
      end else if (soft_clr) begin
        eq_r   <= e;
        pos_r  <= '0;
        aux_r  <= '0;
        lval_r <= 1'b0;
        larm_r <= 1'b0;
      end else begin
        eq_r   <= e;
        pos_r  <= (hs_r == mami_pkg::HS_INDEX && idx_rise) ? '0
                  : pos_r + sx2(q_use);
        if (!c.stepper) aux_r <= aux_r + sx2(q_aux);
        if (latch_hit) begin
          lpos_r <= pos_r;
          lval_r <= 1'b1;
          larm_r <= 1'b0;
        end else if (c.latch_arm_cmd) begin
          lval_r <= 1'b0;
          larm_r <= 1'b1;
        end
      end
    end

    // Homing, find-edge and find-index sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        hs_r      <= mami_pkg::HS_IDLE;
        hm_mode_r <= 1'b0;
        fi_mode_r <= 1'b0;
        stop_r    <= 1'b0;
        idxf_r    <= 1'b0;
        home_q_r  <= 1'b0;
      end else begin
        home_q_r <= home_s[a];
        stop_r   <= 1'b0;
        idxf_r   <= 1'b0;
        if (soft_clr || abort_act) begin
          hs_r <= mami_pkg::HS_IDLE;
        end else begin
          case (hs_r)
            mami_pkg::HS_IDLE: begin
              if (c.homing_cmd | c.find_edge_cmd | c.find_index_cmd) begin
                hs_r      <= mami_pkg::HS_ARMED;
                hm_mode_r <= c.homing_cmd;
                fi_mode_r <= c.find_index_cmd;
              end
            end
            mami_pkg::HS_ARMED: begin
              if (c.begin_motion_cmd) begin
                hs_r <= fi_mode_r ? mami_pkg::HS_INDEX : mami_pkg::HS_SLEW;
              end
            end
            mami_pkg::HS_SLEW: begin
              if (home_tr) begin
                stop_r <= 1'b1;
                hs_r   <= hm_mode_r ? mami_pkg::HS_INDEX : mami_pkg::HS_IDLE;
              end
            end
            mami_pkg::HS_INDEX: begin
              if (idx_rise) begin
                idxf_r <= 1'b1;
                stop_r <= 1'b1;
                hs_r   <= mami_pkg::HS_IDLE;
              end
            end
            default: hs_r <= mami_pkg::HS_IDLE;
          endcase
        end
      end
    end

    // Drive outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        mcmd_r   <= '0;
        scnt_r   <= '0;
        sph_r    <= 1'b0;
        drv_r    <= 1'b0;
        pwm_r    <= 1'b0;
        oe_r     <= 1'b0;
        sgn_r    <= 1'b0;
        amp_r    <= 1'b0;
        lim_q_r  <= 1'b0;
        lim_ev_r <= 1'b0;
      end else begin
        if (sample_tick || motor_off) mcmd_r <= cmd_nxt;
        if (!step_go || scnt_r >= c.step_half) begin
          scnt_r <= '0;
          sph_r  <= step_go & ~sph_r;
        end else begin
          scnt_r <= scnt_r + 1'b1;
        end
        drv_r    <= ~soft_clr & (drv_r | c.motor_on);
        // Undriven pin stays low so a fitted jumper sees a low level
        pwm_r    <= ~drv_r ? 1'b0 : c.stepper ? step_lvl : (pwm_cnt_r < th);
        oe_r     <= drv_r | jmp_s;
        sgn_r    <= c.stepper ? c.step_fwd : mcmd_r[mami_pkg::CMD_W-1];
        amp_r    <= ~(abort_act | off_err);
        lim_q_r  <= fwd_act | rev_act;
        lim_ev_r <= (fwd_act | rev_act) & ~lim_q_r;
      end
    end

    assign motor_cmd_out[a]         = mcmd_r;
    assign pwm_step_o[a]            = pwm_r;
    assign pwm_step_oe[a]           = oe_r;
    assign sign_dir_o[a]            = sgn_r;
    assign amp_en_o[a]              = amp_r;
    assign limit_handler_routine[a] = lim_ev_r;
    assign axis_sts[a] = '{pos: pos_r, aux_pos: aux_r, latch_pos: lpos_r,
                           latch_valid: lval_r, latch_armed: larm_r,
                           slewing: (hs_r == mami_pkg::HS_SLEW) | (hs_r == mami_pkg::HS_INDEX),
                           home_stop: stop_r, index_found: idxf_r};
  end

endmodule

// >>> dv/mami_far.sv
// Encoder source of axis 0: quadrature or pulse-and-direction pattern
module mami_far (
  input  wire logic           sys_clk,
  input  wire logic           go,
  input  wire logic           pd,
  output mami_pkg::mami_enc_s enc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] t_r = 4'h0;
  // One state every fourth clock, well inside the decoder's edge rate
  always @(posedge sys_clk) begin
    t_r <= t_r + {3'h0, go};
  end
  // Pulse mode: channel two held high, so every channel one rise counts down
  assign enc = '{pd ? t_r[2] : t_r[3], pd | (t_r[3] ^ t_r[2]), 1'b0, 1'b0, 1'b0};
endmodule

// >>> dv/mami_checker.sv
// Concurrent checks on the pins of the multi-axis motion logic
module mami_checker (
  input wire logic                           sys_clk,
  input wire logic                           rst_n,
  input wire logic                           sign_magnitude_jumper,
  input wire logic                           abort_n,
  input wire mami_pkg::mami_axis_cmd_s [7:0] axis_cmd,
  input wire mami_pkg::mami_out_cmd_s        out_cmd,
  input wire logic [7:0][15:0]               motor_cmd_out,
  input wire logic [7:0]                     pwm_step_oe,
  input wire logic [7:0]                     sign_dir_o,
  input wire logic [7:0]                     amp_en_o,
  input wire logic                           err_out_n,
  input wire logic [7:0]                     uout,
  input wire mami_pkg::mami_axis_sts_s [7:0] axis_sts,
  input wire logic                           motion_halt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic over;
  // Signed compare, so a negative error is not read as a huge one
  always_comb begin
    over = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if ((axis_cmd[i].pos_err < 0 ? -axis_cmd[i].pos_err : axis_cmd[i].pos_err) >
          $signed({16'h0, axis_cmd[i].error_limit_cmd})) begin
        over = 1'b1;
      end
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_err_out_flag: assert property (1'b1 |=> err_out_n == !$past(over))
    else $error("error output disagrees with axis errors");
  a_abort_drop: assert property (
    !abort_n [*3] |=> amp_en_o == 8'h00 && motion_halt)
    else $error("abort did not drop the enables");
  a_jumper_drive: assert property (
    sign_magnitude_jumper [*3] |=> pwm_step_oe == 8'hff)
    else $error("step pins float with jumper fitted");
  a_port_write: assert property (
    out_cmd.output_port_write_cmd |=> uout == $past(out_cmd.port_val))
    else $error("port write not applied");
  a_bit_clear: assert property (
    out_cmd.clear_output_bit_cmd && !out_cmd.output_port_write_cmd
    |=> !uout[$past(out_cmd.bit_sel)]) else $error("bit clear not applied");
  a_bit_set: assert property (
    out_cmd == {3'b100, out_cmd.bit_sel, out_cmd.port_val} |=> uout[$past(out_cmd.bit_sel)])
    else $error("bit set not applied");
  a_servo_sign: assert property (
    !axis_cmd[1].stepper |=> sign_dir_o[1] == $past(motor_cmd_out[1][15]))
    else $error("sign output does not follow command");
  a_latch_hold: assert property (
    axis_sts[0].latch_valid && !axis_cmd[0].latch_arm_cmd
    |=> $stable(axis_sts[0].latch_pos) || !axis_sts[0].latch_valid)
    else $error("captured position changed");
endmodule
bind mami_top mami_checker u_chk (.sys_clk, .rst_n, .sign_magnitude_jumper, .abort_n, .axis_cmd,
  .out_cmd, .motor_cmd_out, .pwm_step_oe, .sign_dir_o, .amp_en_o, .err_out_n, .uout, .axis_sts,
  .motion_halt);

// >>> dv/multi_axis_motion_io_tb.sv
// Self-checking bench of the multi-axis motion pin logic
module multi_axis_motion_io_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                           sys_clk, rst_n, sign_magnitude_jumper, abort_n, reset_in_n;
  logic                           sample_tick, latch_enable, err_out_n, motion_halt, go, pd;
  logic [7:0]                     lim_fwd, lim_rev, home_sw, pwm_step_o, pwm_step_oe, uout;
  logic [7:0]                     sign_dir_o, amp_en_o, limit_handler_routine;
  logic [15:0]                    gen_in, input_state, input_change;
  logic [7:0][15:0]               motor_cmd_out;
  logic                           restore_req;
  wire mami_pkg::mami_enc_s [7:0] enc_pins;
  mami_pkg::mami_axis_cmd_s [7:0] axis_cmd;
  mami_pkg::mami_axis_sts_s [7:0] axis_sts;
  mami_pkg::mami_pol_s            switch_polarity_cfg;
  mami_pkg::mami_out_cmd_s        out_cmd;
  int                             failures, checked;
  assign enc_pins[7:1] = '0;
  mami_far far (.sys_clk, .go, .pd, .enc(enc_pins[0]));
  mami_top uut (.sys_clk, .rst_n, .sign_magnitude_jumper, .abort_n, .reset_in_n, .enc_pins,
    .lim_fwd, .lim_rev, .home_sw, .gen_in, .sample_tick, .latch_enable, .axis_cmd,
    .switch_polarity_cfg, .out_cmd, .motor_cmd_out, .pwm_step_o, .pwm_step_oe, .sign_dir_o,
    .amp_en_o, .err_out_n, .uout, .axis_sts, .input_state, .input_change,
    .limit_handler_routine, .motion_halt, .restore_req);
  task automatic cy(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string s, input logic [39:0] e, input logic [39:0] v);
    checked++;
    if (v !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic results;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cnt(input int a, input int k, output int n);
    n = 0;
    repeat (k) begin
      cy(1);
      n += pwm_step_o[a];
    end
  endtask
  task automatic ocmd(input logic [2:0] k, input logic [2:0] sel, input logic [7:0] v,
                      input logic [7:0] e);
    out_cmd <= {k, sel, v};
    cy(1);
    out_cmd <= '0;
    cy(1);
    chk("uout", e, uout);
  endtask
  task automatic t_enc(input logic m, input logic [39:0] e);
    pd <= m;
    axis_cmd[0].pulse_dir_fb <= m;
    cy(8);
    go <= 1'b1;
    cy(32);
    go <= 1'b0;
    cy(8);
    chk("pos", e, axis_sts[0].pos);
    $display("encoder mode %b done", m);
  endtask
  task automatic t_latch;
    latch_enable <= 1'b1;
    axis_cmd[0].latch_arm_cmd <= 1'b1;
    axis_cmd[4].latch_arm_cmd <= 1'b1;
    cy(1);
    axis_cmd[0].latch_arm_cmd <= 1'b0;
    axis_cmd[4].latch_arm_cmd <= 1'b0;
    gen_in <= 16'h0011;
    cy(6);
    chk("latch", 40'h2, {axis_sts[0].latch_valid, axis_sts[4].latch_valid});
    gen_in <= 16'h0111;
    cy(6);
    chk("latch", 40'h23, {axis_sts[0].latch_pos, axis_sts[0].latch_valid,
      axis_sts[4].latch_valid});
    $display("latch done");
  endtask
  task automatic t_pwm(input logic [15:0] c, input logic [39:0] th);
    int n;
    axis_cmd[1].motor_cmd <= c;
    sample_tick <= 1'b1;
    cy(1);
    sample_tick <= 1'b0;
    cy(1300);
    chk("cmd", c, motor_cmd_out[1]);
    cnt(1, mami_pkg::PWM_PERIOD, n);
    chk("duty", th, n);
    $display("pwm %h done", c);
  endtask
  task automatic t_stop;
    int n;
    cnt(2, 40, n);
    chk("step", 40'h29, {n, sign_dir_o[2]});
    axis_cmd[5].error_limit_cmd <= 16'h0064;
    axis_cmd[5].pos_err <= 32'h0000_0065;
    cy(3);
    chk("err", 40'h0, err_out_n);
    axis_cmd[5].pos_err <= 32'hffff_ff9c;
    abort_n <= 1'b0;
    cy(5);
    chk("abort", 40'h300, {err_out_n, motion_halt, amp_en_o});
    $display("stop done");
  endtask
  task automatic t_sw;
    int n;
    lim_fwd <= 8'h06;
    axis_cmd[6].find_edge_cmd <= 1'b1;
    cy(1);
    axis_cmd[6].find_edge_cmd <= 1'b0;
    axis_cmd[6].begin_motion_cmd <= 1'b1;
    cy(1);
    axis_cmd[6].begin_motion_cmd <= 1'b0;
    home_sw[6] <= 1'b1;
    cy(2);
    chk("lim", 40'h6, limit_handler_routine);
    chk("ins", 40'h111, input_state);
    cy(1);
    chk("home", 40'h2, {axis_sts[6].slewing, axis_sts[6].home_stop});
    cy(1);
    chk("home", 40'h1, {axis_sts[6].slewing, axis_sts[6].home_stop});
    cnt(2, 20, n);
    chk("blocked", 40'h0, n);
    lim_fwd <= 8'h00;
    reset_in_n <= 1'b0;
    cy(5);
    chk("clear", 40'h0, {uout, axis_sts[0].pos});
    reset_in_n <= 1'b1;
    cy(4);
    chk("restore", 40'h1, restore_req);
    cy(4);
    $display("switch done");
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #1000000;
    failures++;
    results();
  end
  initial begin
    {rst_n, sign_magnitude_jumper, sample_tick, latch_enable, go, pd} = '0;
    {lim_fwd, lim_rev, home_sw, gen_in, switch_polarity_cfg, out_cmd, axis_cmd} = '0;
    {abort_n, reset_in_n, failures, checked} = '0;
    {abort_n, reset_in_n} = 2'h3;
    axis_cmd[1].motor_on = 1'b1;
    // Limits active high, so idle low switch pins do not block motion
    switch_polarity_cfg.limit_active_high = 1'b1;
    axis_cmd[2] = '{stepper: 1'b1, motor_on: 1'b1, step_run: 1'b1, step_fwd: 1'b1,
      step_half: 16'h0004, default: '0};
    axis_cmd[3].motor_off_level_cmd = 16'h1234;
    cy(12);
    rst_n <= 1'b1;
    cy(20);
    chk("off level", 40'h1234, motor_cmd_out[3]);
    ocmd(3'b001, 3'h0, 8'ha5, 8'ha5);
    ocmd(3'b100, 3'h1, 8'h00, 8'ha7);
    ocmd(3'b110, 3'h0, 8'h00, 8'ha6);
    t_enc(1'b0, 40'h8);
    t_latch();
    t_enc(1'b1, 40'h4);
    chk("held", 40'h8, axis_sts[0].latch_pos);
    t_pwm(16'h8000, mami_pkg::INV_MIN_CYC);
    t_pwm(16'h0000, mami_pkg::INV_MIN_CYC + mami_pkg::INV_SPAN_CYC / 2);
    sign_magnitude_jumper <= 1'b1;
    t_pwm(16'h0000, 40'h0);
    t_pwm(16'h8000, mami_pkg::SM_SPAN_CYC);
    chk("sign idle", 40'h6, {sign_dir_o[1], pwm_step_oe[3], pwm_step_o[3]});
    t_sw();
    t_stop();
    results();
  end
endmodule
